// >>> rdc_pkg.sv
// Constants, carriers and state types for the remote-channel conversion
// controller. Assumes a 25 MHz system clock and a byte-level front end.
package rdc_pkg;

    // Register pointers
    localparam logic [7:0] RDC_PTR_RATE_RD = 8'h04;
    localparam logic [7:0] RDC_PTR_RATE_WR = 8'h0a;
    localparam logic [7:0] RDC_PTR_ADJ = 8'h18;
    localparam logic [7:0] RDC_PTR_SWRST = 8'hfc;

    // Reset values and top rate code
    localparam logic [7:0] RDC_RATE_RST = 8'h07;
    localparam logic [7:0] RDC_ADJ_RST = 8'h00;
    localparam logic [7:0] RDC_RDATA_RST = 8'h00;
    localparam logic [7:0] RDC_RATE_MAX = 8'h06;

    // General call
    localparam logic [7:0] RDC_GC_ADDR = 8'h00;
    localparam logic [7:0] RDC_GC_RESET = 8'h06;

    // Beta mode field
    localparam int RDC_BETA_AUTO_BIT = 3;
    localparam logic [3:0] RDC_BETA_DISABLE = 4'h7;
    localparam logic [3:0] RDC_BETA_DIODE_RDBK = 4'hf;
    localparam logic [3:0] RDC_BETA_RST = 4'h0;

    // Timing
    localparam int RDC_CLK_KHZ = 25000;
    localparam int RDC_CONV_AUTO_MS = 126;
    localparam int RDC_CONV_MAN_MS = 93;
    localparam int RDC_RATE_BASE_MS = 16000;
    localparam int RDC_CNT_W = 29;
    localparam int RDC_CONV_AUTO_CYC = RDC_CONV_AUTO_MS * RDC_CLK_KHZ;
    localparam int RDC_CONV_MAN_CYC = RDC_CONV_MAN_MS * RDC_CLK_KHZ;
    localparam int RDC_RATE_BASE_CYC = RDC_RATE_BASE_MS * RDC_CLK_KHZ;

    // Ideality arithmetic, result in millionths
    localparam int RDC_NBASE_DIODE = 1008;
    localparam int RDC_NBASE_GC = 1000;
    localparam int RDC_NADJ_K = 300;
    localparam int RDC_NEFF_SCALE = 1000;
    localparam int RDC_NUM_W = 29;
    localparam int RDC_DEN_W = 9;
    localparam int RDC_NEFF_W = 21;
    localparam logic [RDC_NUM_W-1:0] RDC_NUM_DIODE =
        RDC_NUM_W'(RDC_NBASE_DIODE * RDC_NADJ_K * RDC_NEFF_SCALE);
    localparam logic [RDC_NUM_W-1:0] RDC_NUM_GC =
        RDC_NUM_W'(RDC_NBASE_GC * RDC_NADJ_K * RDC_NEFF_SCALE);
    localparam logic signed [9:0] RDC_DEN_K = 10'sd300;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] ptr;
        logic [7:0] wdata;
    } rdc_reg_req_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } rdc_bus_byte_t;

    typedef struct packed {
        logic valid;
        logic diode;
        logic [2:0] range;
    } rdc_sense_t;

    typedef struct packed {
        logic diode_model;
        logic beta_comp_en;
        logic auto_range;
        logic [2:0] range;
    } rdc_meas_mode_t;

    typedef enum logic [1:0] {
        RDC_ST_IDLE,
        RDC_ST_DETECT,
        RDC_ST_CONVERT
    } rdc_conv_state_t;

endpackage

// >>> rdc_divider.sv
// Restoring unsigned divider, one quotient bit per clock.
// Assumes a nonzero divisor and a start pulse only while not busy.
`timescale 1ns/1ps
`default_nettype none
module rdc_divider #(
    parameter int NUM_W = 29,
    parameter int DEN_W = 9
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Operands
    input wire logic start_i,
    input wire logic [NUM_W-1:0] num_i,
    input wire logic [DEN_W-1:0] den_i,
    // Result
    output logic busy_o,
    output logic done_o,
    output logic [NUM_W-1:0] quot_o
);
    localparam int CW = $clog2(NUM_W + 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        logic [DEN_W-1:0] den;
        logic [DEN_W-1:0] rem;
        logic [NUM_W-1:0] work;
        logic [NUM_W-1:0] res;
    } rdc_div_state_t;

    rdc_div_state_t st_reg;
    rdc_div_state_t st_next;
    logic [DEN_W:0] trial;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        trial = {st_reg.rem, st_reg.work[NUM_W-1]};
        if (start_i && !st_reg.busy) begin
            st_next.busy = 1'b1;
            st_next.cnt = CW'(NUM_W);
            st_next.den = den_i;
            st_next.rem = '0;
            st_next.work = num_i;
        end else if (st_reg.busy) begin
            if (trial >= {1'b0, st_reg.den}) begin
                st_next.rem = DEN_W'(trial - {1'b0, st_reg.den});
                st_next.work = {st_reg.work[NUM_W-2:0], 1'b1};
            end else begin
                st_next.rem = trial[DEN_W-1:0];
                st_next.work = {st_reg.work[NUM_W-2:0], 1'b0};
            end
            st_next.cnt = st_reg.cnt - CW'(1);
            if (st_reg.cnt == CW'(1)) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.res = st_next.work;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o = st_reg.busy;
    assign done_o = st_reg.done;
    assign quot_o = st_reg.res;
endmodule
`default_nettype wire

// >>> rdc_conv_ctrl.sv
// Remote-channel conversion controller: beta mode handling, conversion
// timing and rate, ideality adjust and software reset.
// Assumes a byte-level two-wire front end and an analog front end that
// reports the sensor type once per automatic-mode conversion.
`timescale 1ns/1ps
`default_nettype none
module rdc_conv_ctrl #(
    parameter logic [28:0] CONV_AUTO_CYC = 29'(rdc_pkg::RDC_CONV_AUTO_CYC),
    parameter logic [28:0] CONV_MAN_CYC = 29'(rdc_pkg::RDC_CONV_MAN_CYC),
    parameter logic [28:0] RATE_BASE_CYC = 29'(rdc_pkg::RDC_RATE_BASE_CYC)
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register access from the serial front end
    input wire rdc_pkg::rdc_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rd_hit_o,
    // Received bus bytes, address byte flagged as first
    input wire rdc_pkg::rdc_bus_byte_t bus_byte_i,
    output logic gc_ack_o,
    // Beta mode field as written, and its read-back
    input wire logic [3:0] beta_mode_field_i,
    output logic [3:0] beta_mode_rdbk_o,
    // Analog front end
    input wire logic conv_enable_i,
    input wire rdc_pkg::rdc_sense_t sense_i,
    output rdc_pkg::rdc_meas_mode_t meas_mode_o,
    output logic conv_start_o,
    output logic conv_busy_o,
    output logic conv_done_o,
    // Ideality results
    output logic [7:0] ideality_offset_o,
    output logic [rdc_pkg::RDC_NEFF_W-1:0] neff_o,
    output logic neff_valid_o,
    // Reset to the rest of the device, alerts included
    output logic soft_reset_o
);
    import rdc_pkg::*;

    typedef struct packed {
        logic [7:0] rate;
        logic [7:0] adj;
        logic [3:0] beta_rdbk;
        rdc_meas_mode_t mode;
        rdc_conv_state_t state;
        logic [RDC_CNT_W-1:0] cnt;
        logic [RDC_CNT_W-1:0] conv_len;
        logic swrst;
        logic gc_armed;
        logic [7:0] rdata;
        logic rd_hit;
        logic conv_start;
        logic conv_done;
        logic div_start;
        logic neff_valid;
    } rdc_state_t;

    localparam logic [RDC_CNT_W-1:0] CNT_ONE = 29'h0000001;

    localparam rdc_state_t ST_RST = '{
        rate: RDC_RATE_RST,
        adj: RDC_ADJ_RST,
        beta_rdbk: RDC_BETA_RST,
        mode: '0,
        state: RDC_ST_IDLE,
        cnt: CNT_ONE,
        conv_len: CONV_MAN_CYC,
        swrst: 1'b0,
        gc_armed: 1'b0,
        rdata: RDC_RDATA_RST,
        rd_hit: 1'b0,
        conv_start: 1'b0,
        conv_done: 1'b0,
        div_start: 1'b0,
        neff_valid: 1'b0
    };

    rdc_state_t st_reg;
    rdc_state_t st_next;

    logic [2:0] code_eff;
    logic [RDC_CNT_W-1:0] period;
    logic [RDC_CNT_W-1:0] idle_len;
    logic signed [9:0] den_s;
    logic [RDC_NUM_W-1:0] div_num;
    logic [RDC_DEN_W-1:0] div_den;
    logic [RDC_NUM_W-1:0] div_quot;
    logic div_done;
    logic div_rst_n;

    // Codes above the table run at the fastest listed rate
    assign code_eff = (st_reg.rate > RDC_RATE_MAX) ? RDC_RATE_MAX[2:0]
                                                   : st_reg.rate[2:0];
    // Period halves per code step; idle pads the period out
    assign period = RATE_BASE_CYC >> code_eff;
    assign idle_len = (period > st_reg.conv_len)
                      ? period - st_reg.conv_len
                      : CNT_ONE;

    always_comb begin
        st_next = st_reg;
        st_next.conv_start = 1'b0;
        st_next.conv_done = 1'b0;
        st_next.div_start = 1'b0;
        st_next.swrst = 1'b0;
        st_next.rd_hit = 1'b0;

        // Register writes
        if (reg_req_i.wr) begin
            if (reg_req_i.ptr == RDC_PTR_RATE_WR) begin
                st_next.rate = reg_req_i.wdata;
            end else if (reg_req_i.ptr == RDC_PTR_ADJ) begin
                st_next.adj = reg_req_i.wdata;
            end else if (reg_req_i.ptr == RDC_PTR_SWRST) begin
                st_next.swrst = 1'b1;
            end
        end

        // Register reads; unmapped pointers answer zero, no hit
        if (reg_req_i.rd) begin
            if (reg_req_i.ptr == RDC_PTR_RATE_RD) begin
                st_next.rdata = st_reg.rate;
                st_next.rd_hit = 1'b1;
            end else if (reg_req_i.ptr == RDC_PTR_ADJ) begin
                st_next.rdata = st_reg.adj;
                st_next.rd_hit = 1'b1;
            end else begin
                st_next.rdata = RDC_RDATA_RST;
            end
        end

        // General call: address byte arms, next byte decides
        if (bus_byte_i.valid) begin
            if (bus_byte_i.first) begin
                st_next.gc_armed = (bus_byte_i.data == RDC_GC_ADDR);
            end else if (st_reg.gc_armed) begin
                st_next.gc_armed = 1'b0;
                if (bus_byte_i.data == RDC_GC_RESET) begin
                    st_next.swrst = 1'b1;
                end
            end
        end

        // Conversion sequencer
        case (st_reg.state)
            RDC_ST_IDLE: begin
                if (conv_enable_i) begin
                    if (st_reg.cnt <= CNT_ONE) begin
                        st_next.conv_start = 1'b1;
                        if (beta_mode_field_i[RDC_BETA_AUTO_BIT]) begin
                            // Field sampled once, at conversion start
                            st_next.state = RDC_ST_DETECT;
                        end else begin
                            st_next.mode.auto_range = 1'b0;
                            st_next.mode.range = beta_mode_field_i[2:0];
                            st_next.mode.diode_model =
                                (beta_mode_field_i == RDC_BETA_DISABLE);
                            st_next.mode.beta_comp_en =
                                (beta_mode_field_i != RDC_BETA_DISABLE);
                            st_next.beta_rdbk = beta_mode_field_i;
                            st_next.conv_len = CONV_MAN_CYC;
                            st_next.cnt = CONV_MAN_CYC;
                            st_next.div_start = 1'b1;
                            st_next.state = RDC_ST_CONVERT;
                        end
                    end else begin
                        st_next.cnt = st_reg.cnt - CNT_ONE;
                    end
                end
            end
            RDC_ST_DETECT: begin
                if (sense_i.valid) begin
                    st_next.mode.auto_range = 1'b1;
                    st_next.div_start = 1'b1;
                    st_next.state = RDC_ST_CONVERT;
                    if (sense_i.diode) begin
                        st_next.mode.diode_model = 1'b1;
                        st_next.mode.beta_comp_en = 1'b0;
                        st_next.mode.range = sense_i.range;
                        st_next.beta_rdbk = RDC_BETA_DIODE_RDBK;
                        st_next.conv_len = CONV_MAN_CYC;
                        st_next.cnt = CONV_MAN_CYC;
                    end else begin
                        st_next.mode.diode_model = 1'b0;
                        st_next.mode.beta_comp_en = 1'b1;
                        st_next.mode.range = sense_i.range;
                        st_next.beta_rdbk = {1'b1, sense_i.range};
                        st_next.conv_len = CONV_AUTO_CYC;
                        st_next.cnt = CONV_AUTO_CYC;
                    end
                end
            end
            RDC_ST_CONVERT: begin
                if (st_reg.cnt <= CNT_ONE) begin
                    st_next.conv_done = 1'b1;
                    st_next.state = RDC_ST_IDLE;
                    st_next.cnt = idle_len;
                end else begin
                    st_next.cnt = st_reg.cnt - CNT_ONE;
                end
            end
            default: begin
                st_next.state = RDC_ST_IDLE;
            end
        endcase

        if (st_reg.div_start) begin
            st_next.neff_valid = 1'b0;
        end else if (div_done) begin
            st_next.neff_valid = 1'b1;
        end

        // Registered trigger wipes everything one cycle later
        if (st_reg.swrst) begin
            st_next = ST_RST;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Adjust is signed; 300 minus it always stays within 173..428
    assign den_s = RDC_DEN_K - {{2{st_reg.adj[7]}}, st_reg.adj};
    assign div_den = den_s[RDC_DEN_W-1:0];
    // Diode model or disabled correction uses the higher base
    assign div_num = st_reg.mode.diode_model ? RDC_NUM_DIODE
                                             : RDC_NUM_GC;
    assign div_rst_n = rst_n_i & ~st_reg.swrst;

    rdc_divider #(
        .NUM_W(RDC_NUM_W),
        .DEN_W(RDC_DEN_W)
    ) u_neff_div (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(div_rst_n),
        .start_i(st_reg.div_start),
        .num_i(div_num),
        .den_i(div_den),
        .busy_o(),
        .done_o(div_done),
        .quot_o(div_quot)
    );

    assign reg_rdata_o = st_reg.rdata;
    assign reg_rd_hit_o = st_reg.rd_hit;
    // Ack is combinational so the front end can drive the ninth bit
    assign gc_ack_o = bus_byte_i.valid & bus_byte_i.first &
                      (bus_byte_i.data == RDC_GC_ADDR);
    assign beta_mode_rdbk_o = st_reg.beta_rdbk;
    assign meas_mode_o = st_reg.mode;
    assign conv_start_o = st_reg.conv_start;
    assign conv_busy_o = (st_reg.state != RDC_ST_IDLE);
    assign conv_done_o = st_reg.conv_done;
    assign ideality_offset_o = st_reg.adj;
    assign neff_o = div_quot[RDC_NEFF_W-1:0];
    assign neff_valid_o = st_reg.neff_valid;
    assign soft_reset_o = st_reg.swrst;
endmodule
`default_nettype wire

// >>> rdc_conv_ctrl_assertions.sv
// Port-level checker for the remote-channel conversion controller.
// Assumes sim-scale conversion counts handed on by the bind below.
`timescale 1ns/1ps
`default_nettype none
module rdc_conv_ctrl_assertions #(
    parameter int CONV_AUTO_CYC = 40,
    parameter int CONV_MAN_CYC = 30,
    parameter int RATE_BASE_CYC = 640
) (
    // Clock, reset and inputs
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire rdc_pkg::rdc_reg_req_t reg_req_i,
    input wire rdc_pkg::rdc_bus_byte_t bus_byte_i,
    input wire logic [3:0] beta_mode_field_i,
    input wire logic conv_enable_i,
    input wire rdc_pkg::rdc_sense_t sense_i,
    // Design outputs
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rd_hit_o,
    input wire logic gc_ack_o,
    input wire logic [3:0] beta_mode_rdbk_o,
    input wire rdc_pkg::rdc_meas_mode_t meas_mode_o,
    input wire logic conv_start_o,
    input wire logic conv_busy_o,
    input wire logic conv_done_o,
    input wire logic [7:0] ideality_offset_o,
    input wire logic [rdc_pkg::RDC_NEFF_W-1:0] neff_o,
    input wire logic neff_valid_o,
    input wire logic soft_reset_o
);
    import rdc_pkg::*;
    // Manual start pulse to done pulse spans exactly the programmed length; auto and diode report to done within one cycle of it
    localparam int MAN_LEN = CONV_MAN_CYC;
    localparam int AUTO_LO = CONV_AUTO_CYC - 1;
    localparam int AUTO_HI = CONV_AUTO_CYC + 1;
    localparam int DIO_LO = CONV_MAN_CYC - 1;
    localparam int DIO_HI = CONV_MAN_CYC + 1;
    logic rd_map;
    logic gc_addr;
    logic [20:0] neff_exp;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    assign rd_map = reg_req_i.ptr == RDC_PTR_RATE_RD ||
        reg_req_i.ptr == RDC_PTR_ADJ;
    assign gc_addr = bus_byte_i.valid && bus_byte_i.first &&
        bus_byte_i.data == RDC_GC_ADDR;
    // Floor division, as the divider truncates
    always_comb begin
        neff_exp = 21'((meas_mode_o.diode_model ? 1008 : 1000) * 300000 /
            (300 - int'($signed(ideality_offset_o))));
    end
    sequence gc_cmd_s(logic [7:0] code);
        gc_addr ##1 (bus_byte_i.valid && !bus_byte_i.first &&
            bus_byte_i.data == code);
    endsequence
    sequence cleared_s;
        !conv_busy_o && ideality_offset_o == RDC_ADJ_RST && !neff_valid_o;
    endsequence
    gc_ack_a: assert property (gc_ack_o == gc_addr)
        else $error("general call ack mismatch");
    rd_hit_a: assert property (reg_req_i.rd && rd_map |=> reg_rd_hit_o)
        else $error("mapped read not answered");
    unmapped_rd_a: assert property (reg_req_i.rd && !rd_map |=>
        !reg_rd_hit_o && reg_rdata_o == RDC_RDATA_RST)
        else $error("unmapped read answered");
    fc_reset_a: assert property (reg_req_i.wr &&
        reg_req_i.ptr == RDC_PTR_SWRST |=> soft_reset_o ##1 cleared_s)
        else $error("pointer reset not applied");
    gc_reset_a: assert property (gc_cmd_s(RDC_GC_RESET) |=>
        soft_reset_o ##1 cleared_s)
        else $error("general call reset not applied");
    gc_ignore_a: assert property (gc_cmd_s(8'h05) |=> !soft_reset_o)
        else $error("general call other byte acted on");
    man_len_a: assert property (conv_start_o && !beta_mode_field_i[3] |->
        ##MAN_LEN conv_done_o)
        else $error("manual conversion length wrong");
    auto_len_a: assert property (sense_i.valid && conv_busy_o &&
        !sense_i.diode |-> ##[AUTO_LO:AUTO_HI] conv_done_o)
        else $error("auto conversion length wrong");
    diode_len_a: assert property (sense_i.valid && conv_busy_o &&
        sense_i.diode |-> ##[DIO_LO:DIO_HI] conv_done_o)
        else $error("diode conversion length wrong");
    disable_mode_a: assert property (conv_start_o &&
        beta_mode_field_i == RDC_BETA_DISABLE |-> ##[0:1]
        (meas_mode_o.diode_model && !meas_mode_o.beta_comp_en))
        else $error("disable code mode wrong");
    manual_mode_a: assert property (conv_start_o &&
        beta_mode_field_i < 4'h7 |-> ##[0:1] (meas_mode_o.beta_comp_en &&
        meas_mode_o.range == beta_mode_field_i[2:0]))
        else $error("manual range mode wrong");
    rdbk_auto_a: assert property (conv_done_o && beta_mode_field_i[3] |->
        beta_mode_rdbk_o == (meas_mode_o.diode_model ? RDC_BETA_DIODE_RDBK :
        {1'b1, meas_mode_o.range}))
        else $error("auto read-back wrong");
    neff_value_a: assert property ($rose(neff_valid_o) |->
        neff_o == neff_exp)
        else $error("effective ideality wrong");
endmodule
bind rdc_conv_ctrl rdc_conv_ctrl_assertions #(
    .CONV_AUTO_CYC(CONV_AUTO_CYC),
    .CONV_MAN_CYC(CONV_MAN_CYC),
    .RATE_BASE_CYC(RATE_BASE_CYC)
) rdc_conv_ctrl_assertions_i (.clk_sys_i, .rst_n_i, .reg_req_i, .bus_byte_i,
    .beta_mode_field_i, .conv_enable_i, .sense_i, .reg_rdata_o,
    .reg_rd_hit_o, .gc_ack_o, .beta_mode_rdbk_o, .meas_mode_o, .conv_start_o,
    .conv_busy_o, .conv_done_o, .ideality_offset_o, .neff_o, .neff_valid_o,
    .soft_reset_o);
`default_nettype wire

// >>> rdc_sense_model.sv
// Far-side model of the analog detector: one report per auto conversion.
// Assumes the controller ignores reports outside its detect state.
`timescale 1ns/1ps
`default_nettype none
module rdc_sense_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Controller side
    input wire logic conv_start_i,
    input wire logic auto_i,
    // Scenario controls and the report to the controller
    input wire logic diode_i,
    input wire logic [2:0] range_i,
    input wire logic [3:0] dly_i,
    output rdc_pkg::rdc_sense_t sense_o
);
    import rdc_pkg::*;
    logic [4:0] cnt_reg;
    logic pulse;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 5'h00;
        end else if (conv_start_i && auto_i) begin
            cnt_reg <= {1'b0, dly_i} + 5'h01;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
        end
    end
    assign pulse = cnt_reg == 5'h01;
    // Fields inverted outside the pulse so stale values never pass
    assign sense_o = '{valid: pulse, diode: pulse ? diode_i : ~diode_i,
        range: pulse ? range_i : ~range_i};
endmodule
`default_nettype wire

// >>> tb_rdc_conv_ctrl.sv
// Self-checking bench for the conversion controller.
// Assumes sim-scale counts and the detector model beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_rdc_conv_ctrl;
    import rdc_pkg::*;
    typedef struct packed {
        rdc_reg_req_t req;
        logic [7:0] rdata;
        logic hit;
    } rdc_row_t;
    function automatic rdc_row_t row(bit w, logic [7:0] p, logic [7:0] d,
        bit h);
        row = '{req: '{wr: w, rd: !w, ptr: p, wdata: d}, rdata: d, hit: h};
    endfunction
    localparam rdc_row_t ROWS [14] = '{row(0, 8'h04, 8'h07, 1),
        row(0, 8'h18, 8'h00, 1), row(1, 8'h0a, 8'h03, 0),
        row(0, 8'h04, 8'h03, 1), row(1, 8'h04, 8'h55, 0),
        row(0, 8'h04, 8'h03, 1), row(0, 8'h0a, 8'h00, 0),
        row(1, 8'h18, 8'h80, 0), row(0, 8'h18, 8'h80, 1),
        row(1, 8'h18, 8'h7f, 0), row(0, 8'h18, 8'h7f, 1),
        row(1, 8'h18, 8'hfe, 0), row(0, 8'h18, 8'hfe, 1),
        row(0, 8'hfc, 8'h00, 0)};
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    rdc_reg_req_t reg_req_i = '0;
    rdc_bus_byte_t bus_byte_i = '0;
    logic [3:0] beta_mode_field_i = 4'h0;
    logic conv_enable_i = 1'b0;
    rdc_sense_t sense_i;
    logic [7:0] reg_rdata_o, ideality_offset_o;
    logic reg_rd_hit_o, gc_ack_o, conv_start_o, conv_busy_o, conv_done_o;
    logic neff_valid_o, soft_reset_o;
    logic [3:0] beta_mode_rdbk_o;
    rdc_meas_mode_t meas_mode_o;
    logic [RDC_NEFF_W-1:0] neff_o;
    logic sm_diode = 1'b0;
    logic [2:0] sm_range = 3'h0;
    logic [3:0] sm_dly = 4'h1;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    rdc_conv_ctrl #(.CONV_AUTO_CYC(29'd40), .CONV_MAN_CYC(29'd30),
        .RATE_BASE_CYC(29'd640)) rdc_conv_ctrl_i (.clk_sys_i, .rst_n_i,
        .reg_req_i, .reg_rdata_o, .reg_rd_hit_o, .bus_byte_i, .gc_ack_o,
        .beta_mode_field_i, .beta_mode_rdbk_o, .conv_enable_i, .sense_i,
        .meas_mode_o, .conv_start_o, .conv_busy_o, .conv_done_o,
        .ideality_offset_o, .neff_o, .neff_valid_o, .soft_reset_o);
    rdc_sense_model rdc_sense_model_i (.clk_sys_i, .rst_n_i,
        .conv_start_i(conv_start_o), .auto_i(beta_mode_field_i[3]),
        .diode_i(sm_diode), .range_i(sm_range), .dly_i(sm_dly),
        .sense_o(sense_i));
    always #20 clk_sys_i = ~clk_sys_i;
    task automatic conclude();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Ceiling well above the expected few thousand cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic reg_op(input rdc_reg_req_t r);
        @(posedge clk_sys_i);
        reg_req_i <= r;
        @(posedge clk_sys_i);
        reg_req_i <= '0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
        reg_op('{wr: 1'b0, rd: 1'b1, ptr: p, wdata: 8'h00});
        chk8(reg_rdata_o, exp);
    endtask
    task automatic wait_hi(input bit done, output int n);
        for (n = 0; n < 1000; n++) begin
            @(posedge clk_sys_i);
            #1;
            if ((done ? conv_done_o : conv_busy_o) === 1'b1) break;
        end
        chk1(n < 1000, 1'b1);
    endtask
    // Address and command bytes back to back
    task automatic gc_pair(input logic [7:0] a, input logic [7:0] c);
        @(posedge clk_sys_i);
        bus_byte_i <= '{valid: 1'b1, first: 1'b1, data: a};
        #1;
        chk1(gc_ack_o, a == 8'h00);
        @(posedge clk_sys_i);
        bus_byte_i <= '{valid: 1'b1, first: 1'b0, data: c};
        @(posedge clk_sys_i);
        bus_byte_i <= '0;
        #1;
    endtask
    initial begin
        logic [3:0] code, exp;
        int n;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        chk1(neff_valid_o, 1'b0);
        foreach (ROWS[i]) begin
            reg_op(ROWS[i].req);
            if (ROWS[i].req.rd) begin
                chk8(reg_rdata_o, ROWS[i].rdata);
                chk1(reg_rd_hit_o, ROWS[i].hit);
            end
        end
        for (int i = 0; i < 17; i++) begin
            code = (i < 16) ? 4'(i) : 4'h8;
            @(posedge clk_sys_i);
            beta_mode_field_i <= code;
            sm_diode <= (i == 16);
            sm_range <= ~code[2:0];
            sm_dly <= i[0] ? 4'h9 : 4'h1;
            conv_enable_i <= 1'b1;
            wait_hi(1'b0, n);
            @(posedge clk_sys_i);
            conv_enable_i <= 1'b0;
            wait_hi(1'b1, n);
            exp = (i == 16) ? 4'hf : (code[3] ? {1'b1, ~code[2:0]} : code);
            chk8(8'(beta_mode_rdbk_o), 8'(exp));
            chk1(meas_mode_o.diode_model, code == 4'h7 || i == 16);
            chk1(meas_mode_o.beta_comp_en, code != 4'h7 && i != 16);
            chk1(meas_mode_o.auto_range, code[3]);
        end
        reg_op('{wr: 1'b1, rd: 1'b0, ptr: RDC_PTR_RATE_WR, wdata: 8'h00});
        @(posedge clk_sys_i);
        beta_mode_field_i <= 4'h2;
        conv_enable_i <= 1'b1;
        wait_hi(1'b1, n);
        wait_hi(1'b0, n);
        // Start to start spans the whole rate period
        chk1(n == 640 - 30 - 1, 1'b1);
        @(posedge clk_sys_i);
        conv_enable_i <= 1'b0;
        wait_hi(1'b1, n);
        reg_op('{wr: 1'b1, rd: 1'b0, ptr: RDC_PTR_SWRST, wdata: 8'h5a});
        chk1(soft_reset_o, 1'b1);
        rd_chk(RDC_PTR_RATE_RD, RDC_RATE_RST);
        rd_chk(RDC_PTR_ADJ, RDC_ADJ_RST);
        gc_pair(8'h00, 8'h05);
        chk1(soft_reset_o, 1'b0);
        gc_pair(8'h98, 8'h06);
        chk1(soft_reset_o, 1'b0);
        reg_op('{wr: 1'b1, rd: 1'b0, ptr: RDC_PTR_ADJ, wdata: 8'h33});
        gc_pair(8'h00, 8'h06);
        chk1(soft_reset_o, 1'b1);
        rd_chk(RDC_PTR_ADJ, RDC_ADJ_RST);
        @(posedge clk_sys_i);
        conv_enable_i <= 1'b1;
        wait_hi(1'b0, n);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        conv_enable_i <= 1'b0;
        #1;
        chk1(conv_busy_o, 1'b0);
        rd_chk(RDC_PTR_RATE_RD, RDC_RATE_RST);
        conclude();
    end
endmodule
`default_nettype wire
